// ---- src/vac_pkg.sv ----
package vac_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] A_REF_DIV = 8'h02;
  localparam logic [7:0] A_INTG    = 8'h03;
  localparam logic [7:0] A_FRAC    = 8'h04;
  localparam logic [7:0] A_OSC     = 8'h05;
  localparam logic [7:0] A_MODE    = 8'h06;
  localparam logic [7:0] A_LOCK    = 8'h07;
  localparam logic [7:0] A_CAL     = 8'h0a;
  localparam logic [7:0] A_READ    = 8'h10;
  localparam logic [7:0] A_STAT    = 8'h12;

  // ----------------------------------------
  // field positions and widths
  // ----------------------------------------
  localparam int F_FRAC_MODE = 11;
  localparam int F_RELOCK    = 13;
  localparam int F_CAL_OFF   = 11;
  localparam int F_WIN_EXP   = 0;
  localparam int F_WAIT_K    = 6;
  localparam int F_CLK_EXP   = 13;
  localparam int F_ID_W      = 7;
  localparam int REF_W       = 14;
  localparam int INT_W       = 19;
  localparam int FRAC_W      = 24;
  localparam int OSC_W       = 16;
  localparam int CAL_W       = 15;

  // ----------------------------------------
  // reset values and timing counts
  // ----------------------------------------
  localparam logic [13:0] RST_REF_DIV = 14'h0001;
  localparam logic [8:0]  WAIT_UNIT   = 9'h064;
  localparam logic [4:0]  MAN_LEN     = 5'h10;
  localparam logic [4:0]  CAL_LEN     = 5'h14;

  // ----------------------------------------
  // carriers and states
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } vac_bus_t;

  typedef struct packed {
    logic sck;
    logic sdo;
    logic sen;
  } vac_link_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_SEND = 3'b001,
    S_XFER = 3'b010,
    S_WAIT = 3'b011,
    S_MEAS = 3'b100
  } vac_state_t;

endpackage : vac_pkg

// ---- src/vac_tick_div.sv ----
`timescale 1ns/100ps
`default_nettype none

module vac_tick_div (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // rate select
  input  wire logic [2:0] exp2,
  // enable
  output var  logic       tick
);
  import vac_pkg::*;

  typedef struct packed {
    logic [4:0] cnt;
    logic       tick;
  } vac_div_t;

  vac_div_t   s;
  vac_div_t   next_s;
  logic [4:0] top;

  always_comb begin
    top = 5'((6'h01 << exp2) - 6'h01);
    next_s = s;
    next_s.tick = (s.cnt >= top);
    next_s.cnt = next_s.tick ? 5'h00 : s.cnt + 5'h01;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule : vac_tick_div

`default_nettype wire

// ---- src/vac_link_tx.sv ----
`timescale 1ns/100ps
`default_nettype none

module vac_link_tx #(
  parameter int WORD_W = 16
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rstn,
  // request
  input  wire logic               tick,
  input  wire logic               start,
  input  wire logic [WORD_W-1:0]  word,
  input  wire logic [4:0]         len,
  // link and status
  output var  vac_pkg::vac_link_t link,
  output var  logic               busy,
  output var  logic               done
);
  import vac_pkg::*;

  typedef struct packed {
    logic [WORD_W-1:0] sh;
    logic [4:0]        left;
    logic              busy;
    logic              done;
    vac_link_t         link;
  } vac_tx_t;

  vac_tx_t s;
  vac_tx_t next_s;

  // ----------------------------------------
  // shifter
  // ----------------------------------------
  // bits past the word are sent as zero, so a long frame pads itself
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (!s.busy) begin
      if (start) begin
        next_s.busy = 1'b1;
        next_s.sh = word;
        next_s.left = len;
        next_s.link.sen = 1'b1;
        next_s.link.sck = 1'b0;
        next_s.link.sdo = word[WORD_W-1];
      end
    end else if (tick) begin
      if (!s.link.sck) begin
        next_s.link.sck = 1'b1;
      end else begin
        next_s.link.sck = 1'b0;
        next_s.sh = s.sh << 1;
        next_s.link.sdo = s.sh[WORD_W-2];
        next_s.left = s.left - 5'h01;
        if (s.left == 5'h01) begin
          next_s.busy = 1'b0;
          next_s.done = 1'b1;
          next_s.link.sen = 1'b0;
          next_s.link.sdo = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign link = s.link;
  assign busy = s.busy;
  assign done = s.done;

endmodule : vac_link_tx

`default_nettype wire

// ---- src/vac_sequencer.sv ----
`timescale 1ns/100ps
`default_nettype none

module vac_sequencer #(
  parameter int SW_W = 5
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rstn,
  // register port
  input  wire vac_pkg::vac_bus_t  bus,
  output var  logic [31:0]        rdata,
  // oscillator feedback and lock
  input  wire logic               vco_fb,
  input  wire logic               lock_detect,
  // oscillator link
  output var  vac_pkg::vac_link_t link,
  // loop control
  output var  logic               vtune_hold,
  output var  logic               cal_busy,
  output var  logic [18:0]        prescaler_int,
  output var  logic [23:0]        modulator_frac
);
  import vac_pkg::*;

  typedef struct packed {
    logic [31:0]       rdata;
    logic [REF_W-1:0]  ref_div;
    logic [INT_W-1:0]  intg;
    logic [FRAC_W-1:0] frac;
    logic [OSC_W-1:0]  osc;
    logic [CAL_W-1:0]  calcfg;
    logic              frac_mode;
    logic              relock_en;
    logic              relock_used;
    logic              man_pend;
    logic [7:0]        rb;
    logic [7:0]        code;
    logic [2:0]        bitn;
    logic              final_x;
    vac_state_t        state;
    logic [20:0]       cnt;
    logic [25:0]       edges;
    logic [INT_W-1:0]  pre_int;
    logic [FRAC_W-1:0] mod_frac;
    logic              vs1;
    logic              vs2;
    logic              vs3;
    logic              ls1;
    logic              ls2;
    logic              ls3;
  } vac_seq_t;

  vac_seq_t    s;
  vac_seq_t    next_s;
  logic [2:0]  n_exp;
  logic [2:0]  m_exp;
  logic [49:0] nratio;
  logic [25:0] expv;
  logic [25:0] meas;
  logic [20:0] win;
  logic [8:0]  wait_len;
  logic        cal_off;
  logic        freq_wr;
  logic        relock;
  logic        vedge;
  logic        tick;
  logic        sh_start;
  logic [15:0] sh_word;
  logic [4:0]  sh_len;
  logic        sh_busy;
  logic        sh_done;

  // ----------------------------------------
  // engine clock and link
  // ----------------------------------------
  // engine rate select
  always_comb begin
    case (s.calcfg[F_CLK_EXP +: 2])
      2'h0: m_exp = 3'h0;
      2'h1: m_exp = 3'h2;
      2'h2: m_exp = 3'h4;
      default: m_exp = 3'h5;
    endcase
  end

  vac_tick_div u_div (
    .clk  (clk),
    .rstn (rstn),
    .exp2 (m_exp),
    .tick (tick)
  );

  vac_link_tx #(
    .WORD_W (OSC_W)
  ) u_tx (
    .clk   (clk),
    .rstn  (rstn),
    .tick  (tick),
    .start (sh_start),
    .word  (sh_word),
    .len   (sh_len),
    .link  (link),
    .busy  (sh_busy),
    .done  (sh_done)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    n_exp = s.calcfg[F_WIN_EXP +: 3];
    nratio = {7'h00, s.intg, s.frac} << n_exp;
    expv = nratio[49:24];
    win = {7'h00, s.ref_div} << n_exp;
    wait_len = 9'(s.calcfg[F_WAIT_K +: 2] * WAIT_UNIT);
    cal_off = s.calcfg[F_CAL_OFF];
    vedge = s.vs2 && !s.vs3;
    meas = s.edges + {25'h0000000, vedge};
    freq_wr = bus.wr && ((bus.addr == A_FRAC && s.frac_mode)
                      || (bus.addr == A_INTG && !s.frac_mode));
    relock = s.ls3 && !s.ls2 && s.relock_en && !s.relock_used
             && s.state == S_IDLE && !cal_off;
    sh_start = 1'b0;
    sh_word = {s.osc[15], s.code, s.osc[F_ID_W-1:0]};
    sh_len = CAL_LEN;
    next_s = s;

    // the second and third stages of each synchroniser feed the edge detects
    next_s.vs1 = vco_fb;
    next_s.vs2 = s.vs1;
    next_s.vs3 = s.vs2;
    next_s.ls1 = lock_detect;
    next_s.ls2 = s.ls1;
    next_s.ls3 = s.ls2;

    // register reads, answer one cycle later
    next_s.rdata = 32'h00000000;
    if (bus.rd) begin
      if (bus.addr == A_REF_DIV) begin
        next_s.rdata = 32'(s.ref_div);
      end else if (bus.addr == A_INTG) begin
        next_s.rdata = 32'(s.intg);
      end else if (bus.addr == A_FRAC) begin
        next_s.rdata = 32'(s.frac);
      end else if (bus.addr == A_OSC) begin
        next_s.rdata = 32'(s.osc);
      end else if (bus.addr == A_MODE) begin
        next_s.rdata = 32'(s.frac_mode) << F_FRAC_MODE;
      end else if (bus.addr == A_LOCK) begin
        next_s.rdata = 32'(s.relock_en) << F_RELOCK;
      end else if (bus.addr == A_CAL) begin
        next_s.rdata = 32'(s.calcfg);
      end else if (bus.addr == A_READ) begin
        next_s.rdata = 32'(s.rb);
      end else if (bus.addr == A_STAT) begin
        next_s.rdata = {28'h0000000, s.relock_used, s.state};
      end
    end

    // register writes
    if (bus.wr) begin
      if (bus.addr == A_REF_DIV) begin
        next_s.ref_div = bus.wdata[REF_W-1:0];
      end else if (bus.addr == A_INTG) begin
        next_s.intg = bus.wdata[INT_W-1:0];
      end else if (bus.addr == A_FRAC) begin
        next_s.frac = bus.wdata[FRAC_W-1:0];
      end else if (bus.addr == A_OSC) begin
        next_s.osc = bus.wdata[OSC_W-1:0];
        // with calibration off, forward once the link is free and no search runs
        next_s.man_pend = cal_off;
      end else if (bus.addr == A_MODE) begin
        next_s.frac_mode = bus.wdata[F_FRAC_MODE];
      end else if (bus.addr == A_LOCK) begin
        next_s.relock_en = bus.wdata[F_RELOCK];
      end else if (bus.addr == A_CAL) begin
        next_s.calcfg = bus.wdata[CAL_W-1:0];
      end
    end

    if (bus.wr && cal_off && bus.addr == A_INTG) begin
      next_s.pre_int = bus.wdata[INT_W-1:0];
    end
    if (bus.wr && cal_off && bus.addr == A_FRAC) begin
      next_s.mod_frac = bus.wdata[FRAC_W-1:0];
    end

    if (s.man_pend && !sh_busy && s.state == S_IDLE) begin
      sh_start = 1'b1;
      sh_word = s.osc;
      sh_len = MAN_LEN;
      // a word written in the same cycle stays pending: the set wins
      next_s.man_pend = bus.wr && bus.addr == A_OSC && cal_off;
    end

    case (s.state)
      S_IDLE: begin
        next_s.cnt = 21'h000000;
      end
      S_SEND: begin
        if (!sh_busy) begin
          sh_start = 1'b1;
          next_s.state = S_XFER;
        end
      end
      S_XFER: begin
        if (sh_done) begin
          next_s.cnt = 21'h000000;
          if (s.final_x) begin
            next_s.pre_int = s.intg;
            next_s.mod_frac = s.frac;
            next_s.rb = s.code;
            next_s.state = S_IDLE;
          end else begin
            next_s.state = S_WAIT;
          end
        end
      end
      S_WAIT: begin
        if (s.cnt[8:0] >= wait_len) begin
          next_s.cnt = 21'h000000;
          next_s.edges = 26'h0000000;
          next_s.state = S_MEAS;
        end else if (tick) begin
          next_s.cnt = s.cnt + 21'h000001;
        end
      end
      S_MEAS: begin
        next_s.edges = meas;
        next_s.cnt = s.cnt + 21'h000001;
        if (next_s.cnt == win) begin
          // too slow drops the bit, capacitance out
          if (meas <= expv) begin
            next_s.code[s.bitn] = 1'b0;
          end
          if (s.bitn == 3'h0) begin
            next_s.final_x = 1'b1;
          end else begin
            next_s.bitn = s.bitn - 3'h1;
            next_s.code[s.bitn - 3'h1] = 1'b1;
          end
          next_s.state = S_SEND;
        end
      end
      default: begin
        next_s.state = S_IDLE;
      end
    endcase

    // rewrite of same value also starts
    // restart wins over a running search
    if ((freq_wr && !cal_off) || relock) begin
      next_s.state = S_SEND;
      next_s.bitn = 3'(SW_W - 1);
      next_s.code = 8'h00;
      next_s.code[SW_W-1] = 1'b1;
      next_s.final_x = 1'b0;
      next_s.cnt = 21'h000000;
      // drop a search frame queued now, it would carry the stale code; a pending manual frame still starts
      sh_start = s.man_pend && !sh_busy && s.state == S_IDLE;
      next_s.relock_used = relock;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s <= '0;
      s.ref_div <= RST_REF_DIV;
      s.state <= S_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign vtune_hold = (s.state != S_IDLE);
  assign cal_busy = (s.state != S_IDLE);
  assign rdata = s.rdata;
  assign prescaler_int = s.pre_int;
  assign modulator_frac = s.mod_frac;

endmodule : vac_sequencer

`default_nettype wire

// ---- test/vac_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module vac_props #(
  parameter int SW_W = 5
) (
  // clock and reset
  input wire logic               clk,
  input wire logic               rstn,
  // watched ports
  input wire vac_pkg::vac_bus_t  bus,
  input wire logic [31:0]        rdata,
  input wire logic               vco_fb,
  input wire logic               lock_detect,
  input wire vac_pkg::vac_link_t link,
  input wire logic               vtune_hold,
  input wire logic               cal_busy,
  input wire logic [18:0]        prescaler_int,
  input wire logic [23:0]        modulator_frac
);
  import vac_pkg::*;
  // ----
  // host write mirror
  // ----
  logic        off_q;
  logic        frac_q;
  logic [18:0] int_q;
  logic [23:0] fr_q;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      off_q  <= 1'b0;
      frac_q <= 1'b0;
      int_q  <= '0;
      fr_q   <= '0;
    end else if (bus.wr) begin
      if (bus.addr == A_CAL) off_q <= bus.wdata[F_CAL_OFF];
      if (bus.addr == A_MODE) frac_q <= bus.wdata[F_FRAC_MODE];
      if (bus.addr == A_INTG) int_q <= bus.wdata[18:0];
      if (bus.addr == A_FRAC) fr_q <= bus.wdata[23:0];
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence freq_wr_s;
    bus.wr && !off_q && bus.addr == (frac_q ? A_FRAC : A_INTG);
  endsequence
  sequence man_wr_s;
    bus.wr && off_q;
  endsequence
  hold_release_a: assert property (
    $fell(vtune_hold) |-> $past(link.sen, 2)) else $error("hold released before last frame");
  cal_start_a: assert property (
    freq_wr_s |=> cal_busy) else $error("no calibration after write");
  man_int_a: assert property (
    man_wr_s and bus.addr == A_INTG |-> ##[1:2] prescaler_int == int_q)
    else $error("integer not loaded");
  man_frac_a: assert property (
    man_wr_s and bus.addr == A_FRAC |-> ##[1:2] modulator_frac == fr_q)
    else $error("fraction not loaded");
  loads_frozen_a: assert property (
    cal_busy && $past(cal_busy) |-> $stable(prescaler_int) && $stable(modulator_frac))
    else $error("divider moved during calibration");
  end_load_a: assert property (
    $fell(cal_busy) |-> prescaler_int == int_q && modulator_frac == fr_q)
    else $error("divider not loaded at end");
  link_idle_a: assert property (
    !link.sen |-> !link.sck && !link.sdo) else $error("link active outside frame");
  first_frame_a: assert property (
    $rose(cal_busy) |-> ##[1:70] $rose(link.sen)) else $error("no frame after start");
  off_quiet_a: assert property (
    off_q && !cal_busy |=> !cal_busy) else $error("calibration while disabled");
  read_stands_a: assert property (
    !bus.rd |=> rdata == 32'h0) else $error("read data outside answer");
endmodule : vac_props
bind vac_sequencer vac_props #(.SW_W(SW_W)) i_vac_props (
  .clk, .rstn, .bus, .rdata, .vco_fb, .lock_detect, .link,
  .vtune_hold, .cal_busy, .prescaler_int, .modulator_frac
);
`default_nettype wire

// ---- test/vac_osc_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module vac_osc_model (
  // clock
  input  wire logic               clk,
  // oscillator link
  input  wire vac_pkg::vac_link_t link,
  // band edge and view
  input  wire logic [7:0]         band_edge,
  output var  logic               vco_fb,
  output var  logic [15:0]        word,
  output var  logic [4:0]         sck_cnt
);
  import vac_pkg::*;
  logic        sck_q;
  logic        sen_q;
  logic [15:0] sh;
  initial begin
    {sck_q, sen_q, sh, vco_fb, word, sck_cnt} = '0;
  end
  always @(posedge clk) begin
    sck_q <= link.sck;
    sen_q <= link.sen;
    if (link.sen && !sen_q) begin
      sck_cnt <= 5'h0;
    end else if (link.sen && link.sck && !sck_q) begin
      sck_cnt <= sck_cnt + 5'h1;
      sh <= {sh[14:0], link.sdo};
      if (sck_cnt == 5'hf) word <= {sh[14:0], link.sdo};
    end
    vco_fb <= (word[14:7] < band_edge) ? !vco_fb : 1'b0;
  end
endmodule : vac_osc_model
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
  import vac_pkg::*;
  localparam int SW_W = 5;
  logic        clk, rstn, vco_fb, lock_detect, vtune_hold, cal_busy, sen_q;
  logic [31:0] rdata;
  logic [18:0] prescaler_int, in_v;
  logic [23:0] modulator_frac, fr;
  logic [15:0] word, pre;
  logic [7:0]  band_edge;
  logic [4:0]  sck_cnt;
  vac_bus_t    bus;
  vac_link_t   link;
  int          err_count, cmp_count, frames, f0, len0, len1, t;
  vac_sequencer i_vac_sequencer (.clk, .rstn, .bus, .rdata, .vco_fb, .lock_detect,
    .link, .vtune_hold, .cal_busy, .prescaler_int, .modulator_frac);
  vac_osc_model i_vac_osc_model (.clk, .link, .band_edge, .vco_fb, .word, .sck_cnt);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #2000000;
    err_count++;
    report_and_stop();
  end
  always @(posedge clk) begin
    sen_q <= link.sen;
    if (link.sen && !sen_q) frames <= frames + 1;
  end
  // ----
  // helpers
  // ----
  task automatic step();
    @(posedge clk);
    #1;
  endtask : step
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // strobe dropped a full edge before the next request: no double drive
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
    #1;
  endtask : wr
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    chk(nm, rdata, exp);
  endtask : rdchk
  task automatic cal_run(output int n);
    n = 0;
    while (cal_busy !== 1'b1 && n < 80) begin
      step();
      n++;
    end
    n = 0;
    while (cal_busy === 1'b1 && n < 9000) begin
      step();
      n++;
    end
  endtask : cal_run
  // fast tone gives 32 edges in a 64-cycle window
  function automatic logic [31:0] exp_code(input logic [7:0] b, input logic [18:0] i,
                                           input logic [23:0] f);
    longint e;
    e = (((longint'(i) << 24) + f) << 3) >> 24;
    if (e >= 32) return 32'h0;
    return (b > 8'h20) ? 32'h1f : (b == 8'h0) ? 32'h0 : 32'(b - 8'h1);
  endfunction : exp_code
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  // ----
  // tests
  // ----
  initial begin
    {rstn, bus, band_edge} = '0;
    lock_detect = 1'b1;
    {err_count, cmp_count} = '0;
    void'($urandom(90120));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rdchk("ref_div", A_REF_DIV, 32'h1);
    rdchk("code", A_READ, 32'h0);
    rdchk("unmapped", 8'h33, 32'h0);
    $display("test reset done");
    // a 40 MHz clock keeps every engine rate legal
    for (int mc = 0; mc < 4; mc++) begin
      pre = 16'($urandom);
      wr(A_CAL, 32'h800 | (mc << 13));
      wr(A_OSC, 32'(pre));
      t = 0;
      while (link.sck !== 1'b1 && t < 200) begin step(); t++; end
      t = 0;
      while (link.sck === 1'b1 && t < 200) begin step(); t++; end
      while (link.sck !== 1'b1 && t < 200) begin step(); t++; end
      chk("sck period", t, 2 << ((mc == 3) ? 5 : 2 * mc));
      while (link.sen === 1'b1 && t < 2000) begin step(); t++; end
      chk("osc word", word, pre);
      chk("sck count", sck_cnt, 16);
    end
    // switch word went first, divider follows
    in_v = 19'($urandom);
    wr(A_INTG, 32'(in_v));
    step();
    chk("int now", prescaler_int, in_v);
    fr = 24'($urandom);
    wr(A_MODE, 32'h800);
    wr(A_FRAC, 32'(fr));
    step();
    chk("frac now", modulator_frac, fr);
    chk("no cal", cal_busy, 1'b0);
    $display("test manual done");
    wr(A_REF_DIV, 32'h8);
    wr(A_CAL, 32'h3);
    pre = 16'($urandom) & 16'h807f;
    wr(A_OSC, 32'(pre));
    for (int i = 0; i < 6; i++) begin
      band_edge = (i == 0) ? 8'h0 : (i == 1) ? 8'h21 : 8'($urandom_range(31, 1));
      in_v = (i == 2) ? 19'h5 : 19'($urandom_range(2, 1));
      fr = 24'($urandom);
      wr(A_INTG, 32'(in_v));
      f0 = frames;
      wr(A_FRAC, 32'(fr));
      cal_run(len0);
      chk("frames", frames - f0, SW_W + 1);
      rdchk("code", A_READ, exp_code(band_edge, in_v, fr));
      chk("sent code", word[14:7], exp_code(band_edge, in_v, fr));
      chk("id kept", {word[15], word[6:0]}, {pre[15], pre[6:0]});
      chk("frac", modulator_frac, fr);
      chk("int", prescaler_int, in_v);
    end
    $display("test search done");
    wr(A_FRAC, 32'(fr));
    cal_run(len0);
    chk("rerun", len0 > 0, 1'b1);
    chk("same frac", modulator_frac, fr);
    wr(A_CAL, 32'h43);
    wr(A_FRAC, 32'(fr));
    cal_run(len1);
    chk("wait states", len1 - len0, 500);
    wr(A_CAL, 32'h3);
    wr(A_FRAC, 32'(fr));
    repeat (50) step();
    fr = 24'($urandom);
    wr(A_FRAC, 32'(fr));
    cal_run(len1);
    chk("restart", modulator_frac, fr);
    $display("test rerun done");
    wr(A_LOCK, 32'h2000);
    @(posedge clk) lock_detect <= 1'b0;
    cal_run(len1);
    chk("relock", len1 > 0, 1'b1);
    @(posedge clk) lock_detect <= 1'b1;
    repeat (10) step();
    @(posedge clk) lock_detect <= 1'b0;
    repeat (30) step();
    chk("one relock", cal_busy, 1'b0);
    $display("test relock done");
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
